// file: src/psc_pkg.sv
package psc_pkg;
    localparam int PSC_M_W = 9;
    localparam int PSC_N_W = 2;
    localparam int PSC_T_W = 3;
    localparam int PSC_FRAME_LEN = 14;
    localparam int PSC_T_LSB = 11;
    localparam int PSC_N_LSB = 9;
    localparam int PSC_M_LSB = 0;
    localparam int PSC_BIT_W = 4;
    localparam logic [PSC_BIT_W-1:0] PSC_LAST_BIT = 4'hd;

    // output divider select codes
    localparam logic [PSC_N_W-1:0] PSC_N_DIV2 = 2'h0;
    localparam logic [PSC_N_W-1:0] PSC_N_DIV4 = 2'h1;
    localparam logic [PSC_N_W-1:0] PSC_N_DIV8 = 2'h2;
    localparam logic [PSC_N_W-1:0] PSC_N_DIV1 = 2'h3;
    // clk stands for twice the vco rate: one clk per vco half period
    localparam logic [3:0] PSC_HALF_DIV1 = 4'h1;
    localparam logic [3:0] PSC_HALF_DIV2 = 4'h2;
    localparam logic [3:0] PSC_HALF_DIV4 = 4'h4;
    localparam logic [3:0] PSC_HALF_DIV8 = 4'h8;

    // probe function codes
    localparam logic [PSC_T_W-1:0] PSC_T_REF = 3'h0;
    localparam logic [PSC_T_W-1:0] PSC_T_FOUT = 3'h1;
    localparam logic [PSC_T_W-1:0] PSC_T_GATE = 3'h2;
    localparam logic [PSC_T_W-1:0] PSC_T_HIGH = 3'h3;

    localparam logic PSC_PULLDOWN = 1'b0;
    localparam logic PSC_PULLUP = 1'b1;
    localparam logic [PSC_M_W-1:0] PSC_M_RST = 9'h1ff;
    localparam logic [PSC_N_W-1:0] PSC_N_RST = 2'h3;
    localparam logic [PSC_T_W-1:0] PSC_T_RST = 3'h0;

    // controller register map
    localparam logic [3:0] PSC_REG_CTRL = 4'h0;
    localparam logic [3:0] PSC_REG_CFG = 4'h4;
    localparam logic [3:0] PSC_REG_STAT = 4'h8;
    localparam int PSC_CTRL_SER_GO = 0;
    localparam int PSC_CTRL_PAR_GO = 1;
    localparam int PSC_CTRL_GATE = 2;
    localparam int PSC_CTRL_REF = 3;
    localparam int PSC_CTRL_DRIVE = 4;
    localparam logic [4:0] PSC_CTRL_RST = 5'h1c;
    localparam logic [13:0] PSC_CFG_RST = 14'h19ff;

    // link timing
    localparam int PSC_CLK_NS = 40;
    localparam int PSC_SCLK_HALF_NS = 200;
    localparam int PSC_HOLD_NS = 400;
    localparam logic [7:0] PSC_SCLK_HALF_CYC =
        8'((PSC_SCLK_HALF_NS + PSC_CLK_NS - 1) / PSC_CLK_NS);
    localparam logic [7:0] PSC_HOLD_CYC =
        8'((PSC_HOLD_NS + PSC_CLK_NS - 1) / PSC_CLK_NS);

    typedef enum logic [2:0] {
        PSC_ST_IDLE = 3'h0,
        PSC_ST_SHIFT = 3'h1,
        PSC_ST_SLATCH = 3'h2,
        PSC_ST_PLATCH = 3'h3,
        PSC_ST_PHOLD = 3'h4
    } psc_state_type;
endpackage

// file: src/psc_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface psc_link_if;
    import psc_pkg::*;
    logic ser_clk_drv;
    logic ser_data_drv;
    logic ser_latch_drv;
    logic par_latch_drv;
    logic [PSC_M_W-1:0] loop_div_drv;
    logic [PSC_N_W-1:0] out_div_drv;
    logic out_gate_drv;
    logic ref_sel_drv;
    logic ser_oe_n;
    logic par_oe_n;
    logic ser_clk;
    logic ser_data;
    logic ser_latch;
    logic par_latch;
    logic [PSC_M_W-1:0] loop_div_pins;
    logic [PSC_N_W-1:0] out_div_pins;
    logic out_gate;
    logic reference_source_select;

    // undriven pins fall back to their pull levels
    assign ser_clk = ser_oe_n ? PSC_PULLDOWN : ser_clk_drv; // RL12
    assign ser_data = ser_oe_n ? PSC_PULLDOWN : ser_data_drv; // RL12
    assign ser_latch = ser_oe_n ? PSC_PULLDOWN : ser_latch_drv; // RL12
    assign par_latch = par_oe_n ? PSC_PULLUP : par_latch_drv; // RL13
    assign loop_div_pins = par_oe_n ? {PSC_M_W{PSC_PULLUP}} : loop_div_drv; // RL13
    assign out_div_pins = par_oe_n ? {PSC_N_W{PSC_PULLUP}} : out_div_drv; // RL13
    assign out_gate = par_oe_n ? PSC_PULLUP : out_gate_drv; // RL13
    assign reference_source_select = par_oe_n ? PSC_PULLUP : ref_sel_drv; // RL13

    modport ctl (
        output ser_clk_drv, ser_data_drv, ser_latch_drv, par_latch_drv,
        output loop_div_drv, out_div_drv, out_gate_drv, ref_sel_drv,
        output ser_oe_n, par_oe_n
    );
    modport dev (
        input ser_clk, ser_data, ser_latch, par_latch,
        input loop_div_pins, out_div_pins, out_gate, reference_source_select
    );
endinterface // psc_link_if
`default_nettype wire

// file: src/psc_device.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// (RL1) shift serial data in on clock rise
// (RL2) serial strobe copies shift register to latches
// (RL3) latches follow while strobe high, hold after
// (RL4) parallel strobe loads latches from pins
// (RL5) latches pass pins while strobe low
// (RL6) capture nine-bit loop divider, bit 8 msb
// (RL7) capture two-bit output divider select
// (RL8) divide: 00 by 2, 01 by 4, 10 by 8, 11 by 1
// (RL9) output gate switches only at clean edges
// (RL10) reference: crystal when select high, else external
// (RL11) three serial bits pick the probe function
// (RL12) serial pins and external reference default low
// (RL13) parallel pins, gate, select default high
// (RL14) controller keeps vco in 400 to 800 mhz; here the cfg divider is loaded with no range check
// (RL15) controller loads parallel at power-up first
// (RL16) frame: probe, divider select, loop divider, msb first
module psc_device
    import psc_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    psc_link_if.dev link,
    input wire logic crystal_pins,
    input wire logic ext_reference_in,
    output logic fout,
    output logic probe_out,
    output logic pll_reference,
    output logic [PSC_M_W-1:0] loop_divider,
    output logic [PSC_N_W-1:0] out_div_sel
);
    localparam int SYNC_W = PSC_M_W + PSC_N_W + 6;
    // pull levels as the pins read when open
    localparam logic [SYNC_W-1:0] SYNC_RST = {
        PSC_PULLDOWN, PSC_PULLUP, {PSC_M_W{PSC_PULLUP}},
        {PSC_N_W{PSC_PULLUP}}, PSC_PULLUP, PSC_PULLUP,
        PSC_PULLDOWN, PSC_PULLDOWN
    };

    // link domain: shift register on the serial clock
    logic [PSC_FRAME_LEN-1:0] shift_reg;

    always_ff @(posedge link.ser_clk or negedge arst_n) begin
        if (!arst_n) begin
            shift_reg <= '0;
        end else begin
            shift_reg <= {shift_reg[PSC_FRAME_LEN-2:0], link.ser_data}; // RL1
        end
    end

    // pin synchronisers into the clk domain
    logic [SYNC_W-1:0] pins_raw;
    logic [SYNC_W-1:0] pins_meta;
    logic [SYNC_W-1:0] pins_sync;

    assign pins_raw = {
        link.ser_latch, link.par_latch, link.loop_div_pins,
        link.out_div_pins, link.out_gate, link.reference_source_select,
        crystal_pins, ext_reference_in
    };

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pins_meta <= SYNC_RST; // RL12 RL13
            pins_sync <= SYNC_RST;
        end else begin
            pins_meta <= pins_raw;
            pins_sync <= pins_meta;
        end
    end

    wire logic ser_latch_s;
    wire logic par_latch_s;
    wire logic [PSC_M_W-1:0] loop_div_s;
    wire logic [PSC_N_W-1:0] out_div_s;
    wire logic out_gate_s;
    wire logic ref_sel_s;
    wire logic crystal_s;
    wire logic ext_ref_s;

    assign {ser_latch_s, par_latch_s, loop_div_s, out_div_s,
            out_gate_s, ref_sel_s, crystal_s, ext_ref_s} = pins_sync;

    // frame fields; shift register is quiet while the strobe is high
    wire logic [PSC_T_W-1:0] frame_t;
    wire logic [PSC_N_W-1:0] frame_n;
    wire logic [PSC_M_W-1:0] frame_m;

    assign frame_t = shift_reg[PSC_T_LSB +: PSC_T_W]; // RL16
    assign frame_n = shift_reg[PSC_N_LSB +: PSC_N_W]; // RL16
    assign frame_m = shift_reg[PSC_M_LSB +: PSC_M_W]; // RL16

    // latch openings; parallel wins on divider fields
    wire logic par_open;
    wire logic ser_open;

    assign par_open = !par_latch_s; // RL5
    assign ser_open = ser_latch_s; // RL3

    logic [PSC_T_W-1:0] probe_sel;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            loop_divider <= PSC_M_RST;
            out_div_sel <= PSC_N_RST;
        end else if (par_open) begin
            loop_divider <= loop_div_s; // RL4 RL6
            out_div_sel <= out_div_s; // RL4 RL7
        end else if (ser_open) begin
            loop_divider <= frame_m; // RL2
            out_div_sel <= frame_n; // RL2
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            probe_sel <= PSC_T_RST;
        end else if (ser_open) begin
            probe_sel <= frame_t; // RL2 RL3
        end
    end

    // output divider, clk taken as twice the vco rate
    logic [3:0] half_len;

    always_comb begin
        case (out_div_sel)
            PSC_N_DIV2: half_len = PSC_HALF_DIV2; // RL8
            PSC_N_DIV4: half_len = PSC_HALF_DIV4; // RL8
            PSC_N_DIV8: half_len = PSC_HALF_DIV8; // RL8
            PSC_N_DIV1: half_len = PSC_HALF_DIV1; // RL8
            default: half_len = PSC_HALF_DIV2;
        endcase
    end

    logic [3:0] phase_cnt;
    logic fout_phase;
    logic gate;
    wire logic phase_end;
    wire logic next_phase;
    wire logic rise_now;
    wire logic next_gate;

    assign phase_end = (phase_cnt + 4'h1) >= half_len;
    assign next_phase = phase_end ? !fout_phase : fout_phase;
    assign rise_now = phase_end && !fout_phase;
    // gate changes only as a high phase begins: no runt pulses
    assign next_gate = rise_now ? out_gate_s : gate; // RL9

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            phase_cnt <= '0;
            fout_phase <= 1'b0;
            gate <= 1'b0;
            fout <= 1'b0;
        end else begin
            phase_cnt <= phase_end ? 4'h0 : phase_cnt + 4'h1;
            fout_phase <= next_phase;
            gate <= next_gate;
            fout <= next_phase & next_gate; // RL9
        end
    end

    // reference select
    wire logic next_reference;

    assign next_reference = ref_sel_s ? crystal_s : ext_ref_s; // RL10

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pll_reference <= 1'b0;
        end else begin
            pll_reference <= next_reference;
        end
    end

    // probe output
    logic next_probe;

    always_comb begin
        case (probe_sel)
            PSC_T_REF: next_probe = next_reference; // RL11
            PSC_T_FOUT: next_probe = next_phase & next_gate; // RL11
            PSC_T_GATE: next_probe = next_gate; // RL11
            PSC_T_HIGH: next_probe = 1'b1; // RL11
            default: next_probe = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            probe_out <= 1'b0;
        end else begin
            probe_out <= next_probe;
        end
    end
endmodule // psc_device
`default_nettype wire

// file: src/psc_controller.sv
`timescale 1ns/1ps
`default_nettype none
module psc_controller
    import psc_pkg::*;
#(
    parameter logic [7:0] SCLK_HALF = PSC_SCLK_HALF_CYC,
    parameter logic [7:0] HOLD = PSC_HOLD_CYC
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    psc_link_if.ctl link
);
    logic [4:0] ctrl;
    logic [13:0] cfg;
    logic ser_pend;
    logic par_pend;
    logic boot_done;
    psc_state_type state;
    logic [7:0] tcnt;
    logic [PSC_BIT_W-1:0] bit_idx;

    wire logic req;
    wire logic wr;
    wire logic sel_ctrl;
    wire logic sel_cfg;
    wire logic sel_stat;
    wire logic busy;
    wire logic start_ser;
    wire logic start_par;
    wire logic tdone;

    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = req && wb_we_i;
    assign sel_ctrl = wb_adr_i == PSC_REG_CTRL;
    assign sel_cfg = wb_adr_i == PSC_REG_CFG;
    assign sel_stat = wb_adr_i == PSC_REG_STAT;
    assign busy = state != PSC_ST_IDLE;
    // power-up parallel load comes before anything else
    assign start_par = !busy && (par_pend || !boot_done); // RL15
    assign start_ser = !busy && !start_par && ser_pend;
    assign tdone = (tcnt + 8'h1) >= HOLD;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= req;
            if (req && !wb_we_i) begin
                wb_dat_o <= sel_ctrl ? {27'h0, ctrl} :
                            sel_cfg ? {18'h0, cfg} :
                            sel_stat ? {28'h0, boot_done, ser_pend | par_pend,
                                        busy, busy} : 32'h0;
            end
        end
    end

    // go bits: a write that lands with the start keeps the request
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl <= PSC_CTRL_RST;
            cfg <= PSC_CFG_RST;
            ser_pend <= 1'b0;
            par_pend <= 1'b0;
        end else begin
            ser_pend <= (ser_pend && !start_ser) ||
                        (wr && sel_ctrl && wb_sel_i[0] &&
                         wb_dat_i[PSC_CTRL_SER_GO]);
            par_pend <= (par_pend && !start_par) ||
                        (wr && sel_ctrl && wb_sel_i[0] &&
                         wb_dat_i[PSC_CTRL_PAR_GO]);
            if (wr && sel_ctrl && wb_sel_i[0]) begin
                ctrl <= {wb_dat_i[PSC_CTRL_DRIVE:PSC_CTRL_GATE], 2'h0};
            end
            if (wr && sel_cfg && wb_sel_i[0]) begin
                cfg[7:0] <= wb_dat_i[7:0];
            end
            if (wr && sel_cfg && wb_sel_i[1]) begin
                cfg[13:8] <= wb_dat_i[13:8];
            end
        end
    end

    assign link.ser_oe_n = !ctrl[PSC_CTRL_DRIVE];
    assign link.par_oe_n = !ctrl[PSC_CTRL_DRIVE];
    assign link.out_gate_drv = ctrl[PSC_CTRL_GATE];
    assign link.ref_sel_drv = ctrl[PSC_CTRL_REF]; // RL10

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= PSC_ST_IDLE;
            tcnt <= '0;
            bit_idx <= '0;
            boot_done <= 1'b0;
            link.ser_clk_drv <= 1'b0;
            link.ser_data_drv <= 1'b0;
            link.ser_latch_drv <= 1'b0;
            link.par_latch_drv <= 1'b1;
            link.loop_div_drv <= PSC_M_RST;
            link.out_div_drv <= PSC_N_RST;
        end else begin
            case (state)
                PSC_ST_IDLE: begin
                    tcnt <= '0;
                    if (start_par) begin
                        link.loop_div_drv <= cfg[PSC_M_LSB +: PSC_M_W];
                        link.out_div_drv <= cfg[PSC_N_LSB +: PSC_N_W];
                        link.par_latch_drv <= 1'b0; // RL5
                        state <= PSC_ST_PLATCH;
                    end else if (start_ser) begin
                        bit_idx <= PSC_LAST_BIT;
                        link.ser_data_drv <= cfg[PSC_LAST_BIT]; // RL16
                        state <= PSC_ST_SHIFT;
                    end
                end
                PSC_ST_SHIFT: begin
                    tcnt <= tcnt + 8'h1;
                    if ((tcnt + 8'h1) >= SCLK_HALF) begin
                        tcnt <= '0;
                        link.ser_clk_drv <= !link.ser_clk_drv;
                        if (link.ser_clk_drv && bit_idx == '0) begin
                            link.ser_latch_drv <= 1'b1; // RL3
                            state <= PSC_ST_SLATCH;
                        end else if (link.ser_clk_drv) begin
                            bit_idx <= bit_idx - 4'h1;
                            link.ser_data_drv <= cfg[bit_idx - 4'h1];
                        end
                    end
                end
                PSC_ST_SLATCH: begin
                    tcnt <= tcnt + 8'h1;
                    if (tdone) begin
                        link.ser_latch_drv <= 1'b0; // RL3
                        state <= PSC_ST_IDLE;
                    end
                end
                PSC_ST_PLATCH: begin
                    tcnt <= tcnt + 8'h1;
                    if (tdone) begin
                        tcnt <= '0;
                        link.par_latch_drv <= 1'b1; // RL5
                        state <= PSC_ST_PHOLD;
                    end
                end
                PSC_ST_PHOLD: begin
                    tcnt <= tcnt + 8'h1;
                    if (tdone) begin
                        boot_done <= 1'b1;
                        state <= PSC_ST_IDLE;
                    end
                end
                default: state <= PSC_ST_IDLE;
            endcase
        end
    end
endmodule // psc_controller
`default_nettype wire

// file: sim/psc_link_sva.sv
`timescale 1ns/1ps
`default_nettype none
module psc_link_sva
    import psc_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ser_clk,
    input wire logic ser_data,
    input wire logic ser_latch,
    input wire logic par_latch,
    input wire logic [PSC_M_W-1:0] loop_div_pins,
    input wire logic [PSC_N_W-1:0] out_div_pins,
    input wire logic out_gate,
    input wire logic reference_source_select,
    input wire logic ser_oe_n,
    input wire logic par_oe_n,
    input wire logic crystal_pins,
    input wire logic fout,
    input wire logic probe_out,
    input wire logic pll_reference,
    input wire logic [PSC_M_W-1:0] loop_divider,
    input wire logic [PSC_N_W-1:0] out_div_sel
);
    logic sclk_q, slat_q, plat_q, fout_q, chg, chg_prev;
    logic [PSC_FRAME_LEN-1:0] sh;
    logic [PSC_T_W-1:0] tcode;
    logic [PSC_M_W-1:0] cap_m;
    logic [PSC_N_W-1:0] cap_n, sel_q;
    logic [3:0] hi_cnt;
    logic [7:0] gate_lo;
    wire logic ser_rise = ser_clk && !sclk_q;
    wire logic latch_fall = slat_q && !ser_latch;
    wire logic par_rise = par_latch && !plat_q;
    wire logic fout_fall = fout_q && !fout;
    wire logic sel_moved = out_div_sel != sel_q;
    wire logic [3:0] half_exp = (out_div_sel == PSC_N_DIV2) ? PSC_HALF_DIV2 :
        (out_div_sel == PSC_N_DIV4) ? PSC_HALF_DIV4 :
        (out_div_sel == PSC_N_DIV8) ? PSC_HALF_DIV8 : PSC_HALF_DIV1;

    // edge history, high phase length, divider changes per period
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            {sclk_q, slat_q, plat_q, fout_q} <= 4'h2;
            sel_q <= PSC_N_RST;
            hi_cnt <= 4'h0;
            gate_lo <= 8'h0;
            {chg, chg_prev} <= 2'h3;
        end else begin
            {sclk_q, slat_q, plat_q, fout_q} <=
                {ser_clk, ser_latch, par_latch, fout};
            sel_q <= out_div_sel;
            hi_cnt <= fout ? hi_cnt + 4'h1 : 4'h0;
            gate_lo <= out_gate ? 8'h0 : gate_lo + {7'h0, gate_lo != 8'hff};
            chg <= (chg && !fout_fall) || sel_moved;
            chg_prev <= fout_fall ? chg : chg_prev;
        end
    end

    // reference shift register and captured settings
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sh <= '0;
            tcode <= PSC_T_RST;
            {cap_m, cap_n} <= {PSC_M_RST, PSC_N_RST};
        end else begin
            sh <= ser_rise ? {sh[PSC_FRAME_LEN-2:0], ser_data} : sh;
            tcode <= latch_fall ? sh[PSC_T_LSB +: PSC_T_W] : tcode;
            {cap_m, cap_n} <= par_rise ? {loop_div_pins, out_div_pins}
                : {cap_m, cap_n};
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    sequence s_ser_quiet;
        (!ser_latch && par_latch) [*4];
    endsequence
    sequence s_par_open;
        (!par_latch && $stable({loop_div_pins, out_div_pins})) [*6];
    endsequence

    a_data_setup: assert property (ser_clk && !ser_oe_n |-> $stable(ser_data))
        else $error("serial data moved while shift clock high");
    a_ser_pull: assert property (ser_oe_n |-> !(ser_clk || ser_data || ser_latch))
        else $error("released serial pins not low");
    a_par_pull: assert property (par_oe_n |-> par_latch && out_gate &&
        reference_source_select && (&loop_div_pins) && (&out_div_pins))
        else $error("released parallel pins not high");
    a_ser_copy: assert property (latch_fall && par_latch |-> ##[0:2]
        (loop_divider == sh[PSC_M_LSB +: PSC_M_W] &&
        out_div_sel == sh[PSC_N_LSB +: PSC_N_W]))
        else $error("latches differ from shifted frame");
    a_ser_hold: assert property (s_ser_quiet |=> $stable({loop_divider, out_div_sel}))
        else $error("latches moved while both strobes closed");
    a_par_capture: assert property (par_rise |-> ##5
        (loop_divider == cap_m && out_div_sel == cap_n))
        else $error("parallel capture wrong");
    a_par_pass: assert property (s_par_open |->
        loop_divider == loop_div_pins && out_div_sel == out_div_pins)
        else $error("open parallel latch not passing pins");
    a_half_period: assert property (fout_fall && !chg && !chg_prev &&
        !sel_moved |-> hi_cnt == half_exp)
        else $error("output high phase length wrong");
    a_gate_quiet: assert property (gate_lo > 8'h1e |-> !fout)
        else $error("output active while gated off");
    a_ref_xtal: assert property ((reference_source_select &&
        $stable(crystal_pins)) [*6] |-> pll_reference == crystal_pins)
        else $error("crystal not selected as reference");
    a_probe_high: assert property ((!ser_latch && tcode == PSC_T_HIGH) [*4] |-> probe_out)
        else $error("probe not high");
    a_probe_low: assert property ((!ser_latch && tcode[2]) [*4] |-> !probe_out)
        else $error("probe not low");
endmodule // psc_link_sva
`default_nettype wire

// file: sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
    import psc_pkg::*;
;
    typedef struct packed {
        logic ser;
        logic [13:0] cfg;
        logic [1:0] probe;
    } psc_row_type;

    logic clk, arst_n, wb_cyc, wb_stb, wb_we, wb_ack;
    logic crystal_pins, ext_reference_in, fout, probe_out, pll_reference;
    logic [3:0] wb_adr, wb_sel;
    logic [31:0] wb_dat_w, wb_dat_r, rd;
    logic [PSC_M_W-1:0] loop_divider, m_keep;
    logic [PSC_N_W-1:0] out_div_sel;
    int fails, num_checks;
    psc_row_type rows [6];

    psc_link_if psc_link_if_inst ();
    psc_controller #(.SCLK_HALF(8'h2), .HOLD(8'h8)) psc_controller_inst (
        .clk(clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
        .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack),
        .link(psc_link_if_inst));
    psc_device psc_device_inst (
        .clk(clk), .arst_n(arst_n), .link(psc_link_if_inst),
        .crystal_pins(crystal_pins), .ext_reference_in(ext_reference_in),
        .fout(fout), .probe_out(probe_out), .pll_reference(pll_reference),
        .loop_divider(loop_divider), .out_div_sel(out_div_sel));
    psc_link_sva psc_link_sva_inst (
        .clk(clk), .arst_n(arst_n), .ser_clk(psc_link_if_inst.ser_clk),
        .ser_data(psc_link_if_inst.ser_data),
        .ser_latch(psc_link_if_inst.ser_latch),
        .par_latch(psc_link_if_inst.par_latch),
        .loop_div_pins(psc_link_if_inst.loop_div_pins),
        .out_div_pins(psc_link_if_inst.out_div_pins),
        .out_gate(psc_link_if_inst.out_gate),
        .reference_source_select(psc_link_if_inst.reference_source_select),
        .ser_oe_n(psc_link_if_inst.ser_oe_n),
        .par_oe_n(psc_link_if_inst.par_oe_n), .crystal_pins(crystal_pins),
        .fout(fout), .probe_out(probe_out), .pll_reference(pll_reference),
        .loop_divider(loop_divider), .out_div_sel(out_div_sel));

    task automatic check(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic wb_xfer(input logic we, input logic [3:0] a,
        input logic [31:0] d);
        int n;
        @(posedge clk);
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel} <= {2'h3, we, a, 4'hf};
        wb_dat_w <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 20);
        rd = wb_dat_r;
        {wb_cyc, wb_stb, wb_we} <= 3'h0;
        if (wb_ack !== 1'b1) begin
            fails++;
            give_verdict();
        end
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            wb_xfer(1'b0, PSC_REG_STAT, 32'h0);
            n++;
        end while (rd[2:0] !== 3'h0 && n < 100);
        if (rd[2:0] !== 3'h0) begin
            fails++;
            give_verdict();
        end else begin
            repeat (6) @(posedge clk);
        end
    endtask

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial begin
        repeat (50000) @(posedge clk);
        fails++;
        give_verdict();
    end

    initial begin
        {arst_n, wb_cyc, wb_stb, wb_we, wb_adr, wb_sel} = '0;
        {wb_dat_w, rd, fails, num_checks} = '0;
        crystal_pins = 1'b1;
        ext_reference_in = 1'b0;
        rows[0] = '{1'b0, {3'h0, PSC_N_DIV2, 9'h0a5}, 2'h2};
        rows[1] = '{1'b1, {3'h3, PSC_N_DIV4, 9'h15a}, 2'h1};
        rows[2] = '{1'b1, {3'h5, PSC_N_DIV8, 9'h100}, 2'h0};
        rows[3] = '{1'b0, {3'h1, PSC_N_DIV1, 9'h001}, 2'h0};
        rows[4] = '{1'b1, {3'h2, PSC_N_DIV2, 9'h1fe}, 2'h1};
        rows[5] = '{1'b1, {3'h7, PSC_N_DIV1, 9'h0ff}, 2'h0};
        repeat (2) @(posedge clk);
        check("reset divider", 32'(PSC_M_RST), 32'(loop_divider));
        arst_n <= 1'b1;
        wait_idle();
        wb_xfer(1'b0, PSC_REG_CTRL, 32'h0);
        check("ctrl reset", 32'(PSC_CTRL_RST), rd);
        wb_xfer(1'b0, PSC_REG_CFG, 32'h0);
        check("cfg reset", 32'(PSC_CFG_RST), rd);
        check("boot divider", 32'(PSC_CFG_RST[8:0]), 32'(loop_divider));
        wb_xfer(1'b0, 4'hc, 32'h0);
        check("unmapped read", 32'h0, rd);
        foreach (rows[i]) begin
            wb_xfer(1'b1, PSC_REG_CFG, 32'(rows[i].cfg));
            wb_xfer(1'b1, PSC_REG_CTRL, 32'(PSC_CTRL_RST) | (32'h1 <<
                (rows[i].ser ? PSC_CTRL_SER_GO : PSC_CTRL_PAR_GO)));
            wait_idle();
            check("divider", 32'(rows[i].cfg[8:0]), 32'(loop_divider));
            check("out div", 32'(rows[i].cfg[10:9]), 32'(out_div_sel));
            if (rows[i].probe != 2'h2) begin
                check("probe", 32'(rows[i].probe[0]), 32'(probe_out));
            end
            repeat (40) @(posedge clk);
        end
        // both loads requested at once: second waits
        wb_xfer(1'b1, PSC_REG_CFG, {18'h0, 3'h3, PSC_N_DIV8, 9'h0c3});
        wb_xfer(1'b1, PSC_REG_CTRL, 32'(PSC_CTRL_RST) | 32'h3);
        wb_xfer(1'b0, PSC_REG_STAT, 32'h0);
        check("busy", 32'h1, 32'(rd[2:0] != 3'h0));
        wait_idle();
        check("queued divider", 32'h0c3, 32'(loop_divider));
        check("queued probe", 32'h1, 32'(probe_out));
        wb_xfer(1'b1, PSC_REG_CTRL, 32'h18);
        repeat (30) @(posedge clk);
        for (int k = 0; k < 16; k++) begin
            @(posedge clk);
            check("gated fout", 32'h0, 32'(fout));
        end
        wb_xfer(1'b1, PSC_REG_CTRL, 32'h1c);
        repeat (10) @(posedge clk);
        check("crystal ref", 32'h1, 32'(pll_reference));
        wb_xfer(1'b1, PSC_REG_CTRL, 32'h14);
        repeat (10) @(posedge clk);
        check("ext ref low", 32'h0, 32'(pll_reference));
        {crystal_pins, ext_reference_in} <= 2'h1;
        repeat (10) @(posedge clk);
        check("ext ref high", 32'h1, 32'(pll_reference));
        m_keep = loop_divider;
        wb_xfer(1'b1, PSC_REG_CTRL, 32'h0c);
        repeat (6) @(posedge clk);
        check("idle par latch", 32'h1, 32'(psc_link_if_inst.par_latch));
        check("idle m pins", 32'h1ff, 32'(psc_link_if_inst.loop_div_pins));
        check("idle ser clk", 32'h0, 32'(psc_link_if_inst.ser_clk));
        check("held divider", 32'(m_keep), 32'(loop_divider));
        wb_xfer(1'b1, PSC_REG_CTRL, 32'h1c);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        check("rerun reset", 32'(PSC_M_RST), 32'(loop_divider));
        arst_n <= 1'b1;
        wait_idle();
        wb_xfer(1'b0, PSC_REG_CFG, 32'h0);
        check("cfg rerun", 32'(PSC_CFG_RST), rd);
        give_verdict();
    end
endmodule // tb
`default_nettype wire
